// ---- hw/agc_pkg.sv ----
package agc_pkg;

    // ****************************************************************
    // Register indexes on the plain register port
    // ****************************************************************
    localparam logic [3:0] ADDR_RESULT = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_GAIN = 4'h2;
    localparam logic [3:0] ADDR_DAC0 = 4'h3;
    localparam logic [3:0] ADDR_DAC1 = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int CTRL_CH_LSB = 0;
    localparam int CTRL_CH_W = 4;
    localparam int GAIN_BANK_BIT = 7;
    localparam int GAIN_STEP_W = 2;
    localparam int STAT_NEW_BIT = 0;
    localparam int STAT_BIP_BIT = 1;
    localparam int STAT_DIFF_BIT = 2;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [2:0] DIFF_CH_MASK = 3'h7;

    // ****************************************************************
    // Amplifier banks
    // ****************************************************************
    typedef enum logic {
        AGC_BANK_LOW,
        AGC_BANK_HIGH
    } agc_bank_t;

endpackage : agc_pkg

// ---- hw/agc_result_format.sv ----
`timescale 1ns/1ns
module agc_result_format
    import agc_pkg::*;
#(
    parameter int ADC_W = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic code_valid,
    input wire logic [ADC_W-1:0] code,
    input wire logic bipolar,
    output logic word_valid,
    output logic [15:0] word
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } agc_fmt_state_t;

    agc_fmt_state_t state;
    agc_fmt_state_t next_state;

    initial begin
        if (ADC_W < 2 || ADC_W > 16) begin
            $error("agc_result_format: ADC_W must lie in 2..16");
        end
    end

    // Bipolar codes are already two's complement, so only the sign bit is
    // copied upward; unipolar codes are straight binary and get zeros.
    always_comb begin
        next_state = state;
        next_state.valid = code_valid;
        if (code_valid) begin
            if (bipolar) begin
                next_state.word = {{(16-ADC_W){code[ADC_W-1]}}, code};
            end else begin
                next_state.word = {{(16-ADC_W){1'b0}}, code};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign word_valid = state.valid;
    assign word = state.word;

endmodule : agc_result_format

// ---- hw/agc_converter_ctrl.sv ----
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Functional notes
// - Codes 00-03 pick low bank 1,10,100,500
// - Codes 80-83 pick high bank 1,2,4,8
// - Gain follows last written gain byte
// - Results returned as 16-bit signed words
// - Unipolar result zero-extended, 0 to 4095
// - Bipolar result sign-extended, -2048 to 2047
// - Software picks channel; 8 diff, 16 single
// - Each result latched for host reading
// - Two output channels written independently, 12-bit
// - Output write keeps bits 0-11, drops 12-15
// - Unipolar output code is straight binary
// - Bipolar output code is offset binary, 2048 zero
module agc_converter_ctrl
    import agc_pkg::*;
#(
    parameter int ADC_W = 12,
    parameter int DAC_W = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic in_bipolar,
    input wire logic in_differential,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_code,
    output logic [3:0] mux_channel,
    output logic [7:0] gain_code,
    output logic gain_bank_high,
    output logic [1:0] gain_step,
    output logic [DAC_W-1:0] dac0_code,
    output logic dac0_load,
    output logic [DAC_W-1:0] dac1_code,
    output logic dac1_load
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    initial begin
        if (ADC_W < 2 || ADC_W > 16) begin
            $error("agc_converter_ctrl: ADC_W must lie in 2..16");
        end
        if (DAC_W < 1 || DAC_W > 16) begin
            $error("agc_converter_ctrl: DAC_W must lie in 1..16");
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0] rdata;
        logic [3:0] channel;
        logic [3:0] mux;
        logic [7:0] gain;
        logic bank_high;
        logic [1:0] step;
        logic [15:0] result;
        logic fresh;
        logic [DAC_W-1:0] dac0;
        logic load0;
        logic [DAC_W-1:0] dac1;
        logic load1;
    } agc_state_t;

    agc_state_t state;
    agc_state_t next_state;

    logic fmt_valid;
    logic [15:0] fmt_word;

    // ****************************************************************
    // Result formatting
    // ****************************************************************
    agc_result_format #(
        .ADC_W(ADC_W)
    ) u_format (
        .clk(clk),
        .sys_rst(sys_rst),
        .code_valid(adc_done),
        .code(adc_code),
        .bipolar(in_bipolar),
        .word_valid(fmt_valid),
        .word(fmt_word)
    );

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = (a == b);
    endfunction : hit

    // Only the low three channel bits reach the multiplexer in
    // differential mode, since pairs leave just eight inputs.
    function automatic logic [3:0] mux_select(input logic [3:0] ch,
                                              input logic diff);
        if (diff) begin
            mux_select = {1'b0, ch[2:0] & DIFF_CH_MASK};
        end else begin
            mux_select = ch;
        end
    endfunction : mux_select

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_state.load0 = 1'b0;
        next_state.load1 = 1'b0;
        next_state.rdata = WORD_RESET;

        if (reg_wr) begin
            if (hit(reg_addr, ADDR_CONTROL)) begin
                next_state.channel =
                    reg_wdata[CTRL_CH_LSB +: CTRL_CH_W];
            end
            if (hit(reg_addr, ADDR_GAIN)) begin
                next_state.gain = reg_wdata[7:0];
            end
            // Codes are passed untouched: straight or offset binary is a
            // matter of the analog jumpers, not of this logic.
            if (hit(reg_addr, ADDR_DAC0)) begin
                next_state.dac0 = reg_wdata[DAC_W-1:0];
                next_state.load0 = 1'b1;
            end
            if (hit(reg_addr, ADDR_DAC1)) begin
                next_state.dac1 = reg_wdata[DAC_W-1:0];
                next_state.load1 = 1'b1;
            end
        end

        next_state.mux = mux_select(state.channel, in_differential);

        // Bit 7 chooses the bank, the low bits the step within it.
        next_state.bank_high = state.gain[GAIN_BANK_BIT];
        next_state.step = state.gain[GAIN_STEP_W-1:0];

        // A read of the result clears the fresh flag, but a new word in the
        // same cycle keeps it set so no conversion is silently missed.
        if (reg_rd && hit(reg_addr, ADDR_RESULT)) begin
            next_state.fresh = 1'b0;
        end
        if (fmt_valid) begin
            next_state.result = fmt_word;
            next_state.fresh = 1'b1;
        end

        if (reg_rd) begin
            case (reg_addr)
                ADDR_RESULT: begin
                    next_state.rdata = state.result;
                end
                ADDR_CONTROL: begin
                    next_state.rdata = {12'h000, state.channel};
                end
                ADDR_DAC0: begin
                    next_state.rdata = {{(16-DAC_W){1'b0}}, state.dac0};
                end
                ADDR_DAC1: begin
                    next_state.rdata = {{(16-DAC_W){1'b0}}, state.dac1};
                end
                ADDR_STATUS: begin
                    next_state.rdata[STAT_NEW_BIT] = state.fresh;
                    next_state.rdata[STAT_BIP_BIT] = in_bipolar;
                    next_state.rdata[STAT_DIFF_BIT] = in_differential;
                end
                default: begin
                    next_state.rdata = WORD_RESET;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
            state.gain <= GAIN_RESET;
            state.channel <= CHAN_RESET;
            state.mux <= CHAN_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign mux_channel = state.mux;
    assign gain_code = state.gain;
    assign gain_bank_high = state.bank_high;
    assign gain_step = state.step;
    assign dac0_code = state.dac0;
    assign dac0_load = state.load0;
    assign dac1_code = state.dac1;
    assign dac1_load = state.load1;

endmodule : agc_converter_ctrl

// ---- bench/agc_converter_ctrl_checker.sv ----
`timescale 1ns/1ns
module agc_converter_ctrl_checker
    import agc_pkg::*;
#(
    parameter int ADC_W = 12,
    parameter int DAC_W = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic in_bipolar,
    input wire logic in_differential,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_code,
    input wire logic [3:0] mux_channel,
    input wire logic [7:0] gain_code,
    input wire logic gain_bank_high,
    input wire logic [1:0] gain_step,
    input wire logic [DAC_W-1:0] dac0_code,
    input wire logic dac0_load,
    input wire logic [DAC_W-1:0] dac1_code,
    input wire logic dac1_load
);
    // ****************************************************************
    // Port relations
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // A result read three edges after a conversion, none in between.
    sequence conv_rd;
        adc_done ##1 !adc_done [*2] ##1 reg_rd && reg_addr == ADDR_RESULT;
    endsequence
    sequence gain_wr;
        reg_wr && reg_addr == ADDR_GAIN;
    endsequence
    gain_follow_a: assert property (gain_wr |=>
        gain_code == $past(reg_wdata[7:0])) else $error("gain byte lost");
    bank_step_a: assert property (gain_wr |=> ##1
        gain_bank_high == $past(reg_wdata[7], 2)
        && gain_step == $past(reg_wdata[1:0], 2)) else $error("bad bank");
    dac0_take_a: assert property (reg_wr && reg_addr == ADDR_DAC0
        |=> dac0_load && dac0_code == $past(reg_wdata[11:0]))
        else $error("dac0 write lost");
    dac1_take_a: assert property (reg_wr && reg_addr == ADDR_DAC1
        |=> dac1_load && dac1_code == $past(reg_wdata[11:0]))
        else $error("dac1 write lost");
    dac_alone_a: assert property (dac1_load |->
        $past(reg_wr && reg_addr == ADDR_DAC1)) else $error("dac1 stray");
    diff_mask_a: assert property ($past(in_differential)
        && $past(in_differential, 2) |-> !mux_channel[3])
        else $error("channel not masked");
    chan_sel_a: assert property (reg_wr && reg_addr == ADDR_CONTROL
        && !in_differential ##1 !in_differential
        |=> mux_channel == $past(reg_wdata[3:0], 2))
        else $error("channel wrong");
    result_fmt_a: assert property (conv_rd |=>
        reg_rdata == ($past(in_bipolar, 4)
        ? {{4{$past(adc_code[11], 4)}}, $past(adc_code, 4)}
        : {4'h0, $past(adc_code, 4)})) else $error("result format");
endmodule : agc_converter_ctrl_checker

bind agc_converter_ctrl agc_converter_ctrl_checker
    #(.ADC_W(ADC_W), .DAC_W(DAC_W)) chk_u (.*);

// ---- bench/agc_conv_model.sv ----
`timescale 1ns/1ns
module agc_conv_model (
    input wire logic clk,
    input wire logic start,
    input wire logic slow,
    input wire logic [11:0] value,
    output logic adc_done = 1'b0,
    output logic [11:0] adc_code = 12'h000
);
    logic [11:0] held = 12'h000;
    logic [3:0] cnt = 4'h0;
    // Code lines toggle outside the done pulse so a late sample is caught.
    always @(posedge clk) begin
        adc_done <= 1'b0;
        adc_code <= ~adc_code;
        if (start) begin
            held <= value;
            cnt <= slow ? 4'h9 : 4'h1;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                adc_done <= 1'b1;
                adc_code <= held;
            end
        end
    end
endmodule : agc_conv_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import agc_pkg::*;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, start = 0, slow = 0;
    logic in_bipolar = 0, in_differential = 0;
    logic adc_done, gain_bank_high, dac0_load, dac1_load;
    logic [3:0] reg_addr = 4'h0, mux_channel;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, w;
    logic [11:0] value = 12'h000, adc_code, dac0_code, dac1_code;
    logic [11:0] d0 = 12'h000, d1 = 12'h000;
    logic [7:0] gain_code;
    logic [1:0] gain_step;
    logic [31:0] seed = 32'hd23d3564;
    int errors = 0, tests_run = 0;
    always #25 clk = ~clk;
    agc_converter_ctrl dut_u (.*);
    agc_conv_model conv_u (.*);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    function automatic logic [15:0] fmt(logic b, logic [11:0] c);
        return b ? {{4{c[11]}}, c} : {4'h0, c};
    endfunction : fmt
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic conv(logic b, logic [11:0] c);
        @(posedge clk);
        in_bipolar <= b;
        start <= 1'b1;
        value <= c;
        slow <= c[0];
        @(posedge clk);
        start <= 1'b0;
        repeat (20) begin
            @(posedge clk);
            if (adc_done === 1'b1) break;
        end
        @(posedge clk);
        rd(ADDR_STATUS, w);
        chk("status new", {13'h0, in_differential, b, 1'b1}, w);
        rd(ADDR_RESULT, w);
        chk("result", fmt(b, c), w);
        rd(ADDR_RESULT, w);
        chk("result again", fmt(b, c), w);
        rd(ADDR_STATUS, w);
        chk("status read", {13'h0, in_differential, b, 1'b0}, w);
    endtask : conv
    task automatic end_of_test;
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            w = rnd();
            if (i < 8) w[7:0] = {i[2], 5'h00, i[1:0]};
            wr(ADDR_GAIN, w);
            chk("gain", {8'h00, w[7:0]}, {8'h00, gain_code});
            chk("bank", {13'h0, w[7], w[1:0]},
                {13'h0, gain_bank_high, gain_step});
            w = rnd();
            if (i[0]) d1 = w[11:0];
            else d0 = w[11:0];
            wr(i[0] ? ADDR_DAC1 : ADDR_DAC0, w);
            chk("dac0", {4'h0, d0}, {4'h0, dac0_code});
            chk("dac1", {4'h0, d1}, {4'h0, dac1_code});
            @(posedge clk);
            in_differential <= i[1];
            w = rnd();
            wr(ADDR_CONTROL, w);
            chk("channel", {12'h0, w[3] & !i[1], w[2:0]},
                {12'h0, mux_channel});
            w = rnd();
            conv(i[1], i < 4 ? {i[0], {11{i[1]}}} : w[11:0]);
            $display("test %0d done", i);
        end
        rd(4'hf, w);
        chk("unmapped", 16'h0000, w);
        end_of_test;
    end
    initial begin
        #(2000 * 50);
        errors++;
        end_of_test;
    end
endmodule : testbench
